/* adc_ctrl_checker.sv */
// Purpose: Port checks for the power and output controller.
// Assumes: Bound to adc_power_output_ctrl.
// Notes: Pin paths allow for a two-flop synchroniser.
`timescale 1ns/100ps
module adc_ctrl_checker #(
   parameter int POWER_DOWN_PIN_WAKE_CYCLES = 50
)(
   input wire ref_clk_i,
   input wire rst_i,
   input wire power_down_pin_i,
   input wire serial_data_or_output_mode_pin_i,
   input wire [3:0] lane_o,
   input wire bit_clock_out_o,
   input wire word_frame_clock_out_o,
   input wire drivers_oe_o,
   input wire low_swing_o,
   input wire reference_en_o,
   input wire pll_en_o,
   input wire bias_en_o,
   input wire [3:0] channel_en_o,
   input wire awake_o
);
   localparam int PD_MAX = POWER_DOWN_PIN_WAKE_CYCLES + 4;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_pd_hiz: assert property (power_down_pin_i [*3] |-> !drivers_oe_o)
      else $error("drivers on in power-down");
   a_pd_off: assert property (!drivers_oe_o |-> !(pll_en_o | reference_en_o | bias_en_o))
      else $error("analog still on in power-down");
   a_pd_exit: assert property (!power_down_pin_i [*3] |-> drivers_oe_o)
      else $error("drivers off after pin low");
   a_pd_wake: assert property ($rose(drivers_oe_o) |-> !awake_o [*3] ##[1:PD_MAX] awake_o)
      else $error("power-down wake time wrong");
   a_stby_pll: assert property (drivers_oe_o && !reference_en_o |-> pll_en_o)
      else $error("pll off in standby");
   a_stby_wake: assert property ($rose(reference_en_o) && $past(pll_en_o) |-> ##[1:62] awake_o)
      else $error("standby wake too slow");
   a_lane_off: assert property ((lane_o & ~channel_en_o & ~$past(channel_en_o)) == 4'h0)
      else $error("disabled lane active");
   a_frame_len: assert property ($rose(word_frame_clock_out_o) |->
      word_frame_clock_out_o [*6] ##1 !word_frame_clock_out_o)
      else $error("frame width wrong");
   a_bclk_rate: assert property ($rose(word_frame_clock_out_o) |->
      $changed(bit_clock_out_o) [*6] ##1 $changed(bit_clock_out_o) [*6])
      else $error("bit clock count wrong");
   a_swing_pin: assert property (serial_data_or_output_mode_pin_i [*3] |-> low_swing_o)
      else $error("mode pin ignored");
   c_word: cover property ($rose(word_frame_clock_out_o));
   c_pd: cover property ($fell(drivers_oe_o));
   c_wake: cover property ($rose(awake_o));
   c_off: cover property (channel_en_o != 4'hF && word_frame_clock_out_o);
endmodule
bind adc_power_output_ctrl adc_ctrl_checker #(.POWER_DOWN_PIN_WAKE_CYCLES(POWER_DOWN_PIN_WAKE_CYCLES)) u_chk (
   .ref_clk_i, .rst_i, .power_down_pin_i, .serial_data_or_output_mode_pin_i, .lane_o,
   .bit_clock_out_o, .word_frame_clock_out_o, .drivers_oe_o, .low_swing_o, .reference_en_o,
   .pll_en_o, .bias_en_o, .channel_en_o, .awake_o
);

/* adc_ctrl_map.vh */
// Purpose: Register map, field positions, reset values and timing for the
//          converter power and output mode controller.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, reference clock in MHz.
// Notes:   Definitions only; included by its bare name.
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CTRL_OFS 4'h0
`define STATUS_OFS 4'h4

// ****************************************
// Control fields
// ****************************************
`define CTRL_STANDBY_BIT 0
`define CTRL_LOW_SWING_BIT 1
`define CTRL_DRIVE_BOOST_BIT 2
`define CTRL_TWOS_BIT 3
`define CTRL_CH_PD_LSB 4
`define CTRL_CH_PD_MSB 7
`define CTRL_RESET 8'h00

// ****************************************
// Status fields
// ****************************************
`define STAT_POWER_DOWN_BIT 0
`define STAT_STANDBY_BIT 1
`define STAT_AWAKE_BIT 2
`define STAT_FIFO_EMPTY_BIT 3
`define STAT_FIFO_FULL_BIT 4
`define STAT_LANES_LSB 8

// ****************************************
// Data format and timing
// ****************************************
`define SAMPLE_BITS 12
`define NUM_CHANNELS 4
`define HALF_WORD_BITS 6
`define REF_CLK_MHZ 100
`define STANDBY_WAKE_NS 600
`define POWER_DOWN_PIN_WAKE_US 375
`define STANDBY_WAKE_CYC ((`STANDBY_WAKE_NS * `REF_CLK_MHZ + 999) / 1000)
`define POWER_DOWN_PIN_WAKE_CYC (`POWER_DOWN_PIN_WAKE_US * `REF_CLK_MHZ)

`endif

/* adc_power_output_ctrl.v */
// Purpose: Power state and output mode control of a four-channel
//          serial-output converter, with its lane serializers.
// Assumes: ref_clk_i at 100 MHz; sample clock, power-down and mode pins
//          arrive from outside and are synchronised here.
// Notes:   One bit per reference cycle; the sample period must exceed
//          twelve reference cycles.
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`include "adc_ctrl_map.vh"

module adc_power_output_ctrl #(
   parameter POWER_DOWN_PIN_WAKE_CYCLES = `POWER_DOWN_PIN_WAKE_CYC
)(
   input wire ref_clk_i,
   input wire rst_i,
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output wire [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   input wire power_down_pin_i,
   input wire serial_data_or_output_mode_pin_i,
   input wire sample_clk_i,
   input wire sample_valid_i,
   output wire sample_ready_o,
   input wire [47:0] sample_data_i,
   output wire [3:0] lane_o,
   output wire bit_clock_out_o,
   output wire word_frame_clock_out_o,
   output wire drivers_oe_o,
   output wire low_swing_o,
   output wire drive_boost_o,
   output wire reference_en_o,
   output wire ref_buffer_en_o,
   output wire pll_en_o,
   output wire bias_en_o,
   output wire [3:0] channel_en_o,
   output wire awake_o
);
   localparam ST_OFF = 2'b00;
   localparam ST_IDLE = 2'b01;
   localparam ST_SHIFT = 2'b10;
   localparam LAST_BIT_I = `SAMPLE_BITS - 1;
   localparam HALF_BIT_I = `HALF_WORD_BITS - 1;
   localparam STBY_WAKE_I = `STANDBY_WAKE_CYC;
   localparam [3:0] LAST_BIT = LAST_BIT_I[3:0];
   localparam [3:0] HALF_BIT = HALF_BIT_I[3:0];
   localparam [15:0] STBY_WAKE = STBY_WAKE_I[15:0];
   localparam [15:0] PD_WAKE = POWER_DOWN_PIN_WAKE_CYCLES[15:0];

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg pd_s1_q;
   reg pd_s2_q;
   reg mode_s1_q;
   reg mode_s2_q;
   reg sclk_s1_q;
   reg sclk_s2_q;
   reg sclk_prev_q;

   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pd_s1_q <= 1'b0;
         pd_s2_q <= 1'b0;
         mode_s1_q <= 1'b0;
         mode_s2_q <= 1'b0;
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         pd_s1_q <= power_down_pin_i;
         pd_s2_q <= pd_s1_q;
         mode_s1_q <= serial_data_or_output_mode_pin_i;
         mode_s2_q <= mode_s1_q;
         sclk_s1_q <= sample_clk_i;
         sclk_s2_q <= sclk_s1_q;
         sclk_prev_q <= sclk_s2_q;
      end
   end

   wire full_pd = pd_s2_q;
   wire sample_edge = sclk_s2_q & ~sclk_prev_q;

   // ****************************************
   // Register slave
   // ****************************************
   reg [7:0] ctrl_q;
   reg ack_q;
   reg [31:0] rdata_q;
   reg [15:0] wake_cnt_q;
   wire fifo_empty;
   wire fifo_full;
   wire req = avs_read_i | avs_write_i;
   wire standby = ctrl_q[`CTRL_STANDBY_BIT];
   wire [3:0] ch_pd = ctrl_q[`CTRL_CH_PD_MSB:`CTRL_CH_PD_LSB];
   wire [31:0] status;

   assign avs_waitrequest_o = req & ~ack_q;
   assign avs_readdata_o = rdata_q;
   assign awake_o = (wake_cnt_q == 16'h0000) & ~full_pd & ~standby;
   assign status = {20'h00000, channel_en_o, 3'b000, fifo_full, fifo_empty,
                    awake_o, standby, full_pd};

   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= `CTRL_RESET;
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         // One wait cycle, then the answer at the next edge
         ack_q <= req & ~ack_q;
         if (req & ~ack_q)
         begin
            if (avs_address_i == `CTRL_OFS)
               rdata_q <= {24'h000000, ctrl_q};
            else if (avs_address_i == `STATUS_OFS)
               rdata_q <= status;
            else
               rdata_q <= 32'h00000000;
         end
         if (avs_write_i & ack_q & avs_byteenable_i[0] & (avs_address_i == `CTRL_OFS))
            ctrl_q <= avs_writedata_i[7:0];
      end
   end

   // ****************************************
   // Power control and wake timer
   // ****************************************
   assign reference_en_o = ~full_pd & ~standby;
   assign ref_buffer_en_o = ~full_pd & ~standby;
   assign bias_en_o = ~full_pd & ~standby;
   assign pll_en_o = ~full_pd;
   assign channel_en_o = ~ch_pd & {4{~full_pd & ~standby}};
   assign drivers_oe_o = ~full_pd;
   assign low_swing_o = ctrl_q[`CTRL_LOW_SWING_BIT] | mode_s2_q;
   assign drive_boost_o = ctrl_q[`CTRL_DRIVE_BOOST_BIT];

   // Recovery time after power-down is the worst case; software may wait less
   // Count is held full while asleep, so awake_o cannot flash high
   // in the cycle at which the sleep condition ends
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wake_cnt_q <= 16'h0000;
      end
      else
      begin
         if (full_pd)
            wake_cnt_q <= PD_WAKE;
         else if (standby & (wake_cnt_q <= STBY_WAKE))
            wake_cnt_q <= STBY_WAKE;
         else if (wake_cnt_q != 16'h0000)
            wake_cnt_q <= wake_cnt_q - 16'h0001;
      end
   end

   // ****************************************
   // Sample buffer
   // ****************************************
   wire fifo_valid;
   wire [47:0] fifo_data;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [3:0] bit_cnt_q;
   wire load = (state_q == ST_IDLE) & sample_edge & fifo_valid;
   wire shift = (state_q == ST_SHIFT) & (bit_cnt_q != LAST_BIT);

   sample_fifo #(
      .WIDTH(48),
      .DEPTH(16),
      .AW(4)
   ) u_fifo (
      .clk_i(ref_clk_i),
      .rst_i(rst_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(sample_ready_o),
      .in_data_i(sample_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(load),
      .out_data_o(fifo_data),
      .empty_o(fifo_empty),
      .full_o(fifo_full)
   );

   // ****************************************
   // Word sequencer
   // ****************************************
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_OFF:
            if (~full_pd & ~standby)
               state_d = ST_IDLE;
         ST_IDLE:
            if (full_pd | standby)
               state_d = ST_OFF;
            else if (load)
               state_d = ST_SHIFT;
         ST_SHIFT:
            if (full_pd | standby)
               state_d = ST_OFF;
            else if (bit_cnt_q == LAST_BIT)
               state_d = ST_IDLE;
         default:
            state_d = ST_OFF;
      endcase
   end

   reg frame_q;
   reg bitclk_q;

   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_OFF;
         bit_cnt_q <= 4'h0;
         frame_q <= 1'b0;
         bitclk_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         if (state_d == ST_OFF)
         begin
            bit_cnt_q <= 4'h0;
            frame_q <= 1'b0;
            bitclk_q <= 1'b0;
         end
         else if (load)
         begin
            bit_cnt_q <= 4'h0;
            frame_q <= 1'b1;
            bitclk_q <= ~bitclk_q;
         end
         else if (shift)
         begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            // Twelve toggles per word give six bit-clock periods
            bitclk_q <= ~bitclk_q;
            if (bit_cnt_q == HALF_BIT)
               frame_q <= 1'b0;
         end
      end
   end

   assign bit_clock_out_o = bitclk_q;
   assign word_frame_clock_out_o = frame_q;

   // ****************************************
   // Lanes
   // ****************************************
   wire twos = ctrl_q[`CTRL_TWOS_BIT];

   genvar ch;
   generate
      for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1)
      begin : g_lane
         // Offset binary 2048 is zero; flipping the MSB gives twos complement
         wire [11:0] word = fifo_data[ch*12 +: 12] ^ {twos, 11'h000};
         lane_serializer #(
            .WIDTH(`SAMPLE_BITS)
         ) u_ser (
            .clk_i(ref_clk_i),
            .rst_i(rst_i),
            .enable_i(channel_en_o[ch]),
            .load_i(load),
            .shift_i(shift),
            .word_i(word),
            .lane_o(lane_o[ch])
         );
      end
   endgenerate
endmodule

/* lane_receiver_model.sv */
// Purpose: Far-side receiver that deserialises the four lanes.
// Assumes: Reference clock oversamples the bit clock.
// Notes: Words seen while not awake are dropped.
`timescale 1ns/100ps
module lane_receiver_model (
   input wire ref_clk_i,
   input wire [3:0] lane_i,
   input wire bclk_i,
   input wire frame_i,
   input wire oe_i,
   input wire awake_i,
   output logic word_valid_o,
   output logic [47:0] word_o
);
   logic bclk_q = 1'b0;
   logic frame_q = 1'b0;
   logic [47:0] sh = 48'h0;
   int cnt = 0;
   always @(posedge ref_clk_i)
   begin
      word_valid_o <= 1'b0;
      bclk_q <= bclk_i;
      frame_q <= frame_i;
      // Both bit clock edges carry a bit
      if (oe_i === 1'b1 && bclk_i !== bclk_q)
      begin
         if (frame_i && !frame_q)
            cnt = 0;
         for (int l = 0; l < 4 && cnt < 12; l++)
            sh[12 * l + 11 - cnt] = lane_i[l];
         cnt++;
         if (cnt == 12 && awake_i === 1'b1)
         begin
            word_o <= sh;
            word_valid_o <= 1'b1;
         end
      end
   end
endmodule

/* lane_serializer.v */
// Purpose: Shifts one channel's sample word out MSB first on its lane.
// Assumes: load_i and shift_i come from the word sequencer.
// Notes:   A disabled lane is held low.
`timescale 1ns/100ps
module lane_serializer #(
   parameter WIDTH = 12
)(
   input wire clk_i,
   input wire rst_i,
   input wire enable_i,
   input wire load_i,
   input wire shift_i,
   input wire [WIDTH-1:0] word_i,
   output wire lane_o
);
   reg [WIDTH-1:0] shreg_q;

   assign lane_o = shreg_q[WIDTH-1];

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         shreg_q <= {WIDTH{1'b0}};
      else if (!enable_i)
         shreg_q <= {WIDTH{1'b0}};
      else if (load_i)
         shreg_q <= word_i;
      else if (shift_i)
         shreg_q <= {shreg_q[WIDTH-2:0], 1'b0};
   end
endmodule

/* sample_fifo.v */
// Purpose: Synchronous FIFO holding converted sample words ahead of the lanes.
// Assumes: One clock; pop only while out_valid_o is high.
// Notes:   Read data come from a register, so valid drops for one cycle
//          after each pop while the next word is fetched.
`timescale 1ns/100ps
module sample_fifo #(
   parameter WIDTH = 48,
   parameter DEPTH = 16,
   parameter AW = 4
)(
   input wire clk_i,
   input wire rst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   output wire empty_o,
   output wire full_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [WIDTH-1:0] rd_data_q;
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] count_q;
   reg stale_q;
   wire push;
   wire pop;

   assign full_o = (count_q == DEPTH[AW:0]);
   assign empty_o = (count_q == {(AW+1){1'b0}});
   assign in_ready_o = ~full_o;
   assign out_valid_o = ~empty_o & ~stale_q;
   assign out_data_o = rd_data_q;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr_q] <= in_data_i;
      rd_data_q <= mem[rd_ptr_q];
   end

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         stale_q <= 1'b1;
      end
      else
      begin
         // Word fetched from memory needs one edge to reach the register
         stale_q <= pop | empty_o;
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
         if (push & ~pop)
            count_q <= count_q + 1'b1;
         else if (pop & ~push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the power and output controller.
// Assumes: 100 MHz reference clock, 125 ns sample clock.
// Notes: Expected words come from a queue model of the lanes.
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   localparam int PDW = 50;
   logic ref_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, sample_clk_i;
   logic [3:0] avs_address_i, avs_byteenable_i, lane_o, channel_en_o;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic power_down_pin_i, serial_data_or_output_mode_pin_i, sample_valid_i, sample_ready_o;
   logic bit_clock_out_o, word_frame_clock_out_o, drivers_oe_o, low_swing_o, drive_boost_o;
   logic reference_en_o, ref_buffer_en_o, pll_en_o, bias_en_o, awake_o, rx_valid, sclk_run;
   logic [47:0] sample_data_i, rx_word, e;
   logic [7:0] cfg;
   logic [7:0] modes[4] = '{8'h00, 8'h08, 8'h58, 8'hA0};
   logic [47:0] exp_q[$];
   int bad_count, cmp_count, cyc, n;
   adc_power_output_ctrl #(.POWER_DOWN_PIN_WAKE_CYCLES(PDW)) dut (.ref_clk_i, .rst_i, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .power_down_pin_i, .serial_data_or_output_mode_pin_i, .sample_clk_i,
      .sample_valid_i, .sample_ready_o, .sample_data_i, .lane_o, .bit_clock_out_o,
      .word_frame_clock_out_o, .drivers_oe_o, .low_swing_o, .drive_boost_o, .reference_en_o,
      .ref_buffer_en_o, .pll_en_o, .bias_en_o, .channel_en_o, .awake_o);
   lane_receiver_model rx (.ref_clk_i, .lane_i(lane_o), .bclk_i(bit_clock_out_o),
      .frame_i(word_frame_clock_out_o), .oe_i(drivers_oe_o), .awake_i(awake_o),
      .word_valid_o(rx_valid), .word_o(rx_word));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // Odd offset keeps sample edges clear of reference edges
   initial
   begin
      sample_clk_i = 1'b0;
      #3.7;
      forever #62.5 if (sclk_run) sample_clk_i = ~sample_clk_i;
   end
   function automatic logic [47:0] expw(input logic [47:0] d);
      logic [47:0] r;
      r = d;
      for (int c = 0; c < 4; c++)
      begin
         if (cfg[3]) r[12 * c + 11] = ~r[12 * c + 11];
         if (cfg[4 + c]) r[12 * c +: 12] = 12'h000;
      end
      return r;
   endfunction
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         bad_count++;
         wrap_up();
      end
      if (rx_valid === 1'b1)
      begin
         e = exp_q.size() ? exp_q.pop_front() : 48'hX;
         `CHK(rx_word, e)
      end
   end
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do
         @(posedge ref_clk_i);
      while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic setcfg(input logic [7:0] v);
      bus(1'b1, 4'h0, {24'h0, v});
      cfg = v;
      @(posedge ref_clk_i);
   endtask
   task automatic push(input logic [47:0] d);
      @(posedge ref_clk_i);
      sample_valid_i <= 1'b1;
      sample_data_i <= d;
      do
         @(posedge ref_clk_i);
      while (sample_ready_o !== 1'b1);
      exp_q.push_back(expw(d));
      sample_valid_i <= 1'b0;
   endtask
   task automatic drain();
      for (n = 0; n < 2000 && exp_q.size() > 0; n++)
         @(posedge ref_clk_i);
      `CHK(exp_q.size(), 0)
   endtask
   task automatic wake(input int lo, input int hi);
      for (n = 0; n < 200 && awake_o !== 1'b1; n++)
         @(posedge ref_clk_i);
      `CHK(n >= lo && n <= hi, 1'b1)
   endtask
   initial
   begin
      rst_i = 1'b1;
      {avs_read_i, avs_write_i, power_down_pin_i, serial_data_or_output_mode_pin_i} = 4'h0;
      avs_address_i = 4'h0;
      avs_byteenable_i = 4'hF;
      avs_writedata_i = 32'h0;
      sample_valid_i = 1'b0;
      sample_data_i = 48'h0;
      sclk_run = 1'b1;
      cfg = 8'h00;
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      void'($urandom(19));
      bus(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(low_swing_o, 1'b0)
      bus(1'b0, 4'hC, 32'h0);
      `CHK(rd, 32'h0)
      push({12'hFFF, 12'h800, 12'h7FF, 12'h000});
      foreach (modes[i])
      begin
         setcfg(modes[i]);
         `CHK(channel_en_o, ~modes[i][7:4])
         repeat (4) push(48'({$urandom, $urandom}));
         drain();
      end
      setcfg(8'h06);
      `CHK({low_swing_o, drive_boost_o}, 2'h3)
      bus(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h6)
      setcfg(8'h00);
      serial_data_or_output_mode_pin_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      `CHK({low_swing_o, drive_boost_o}, 2'h2)
      serial_data_or_output_mode_pin_i <= 1'b0;
      setcfg(8'h01);
      `CHK({pll_en_o, reference_en_o, bias_en_o, awake_o}, 4'h8)
      setcfg(8'h00);
      wake(55, 62);
      power_down_pin_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      `CHK(drivers_oe_o, 1'b0)
      `CHK({pll_en_o, reference_en_o, ref_buffer_en_o, bias_en_o}, 4'h0)
      bus(1'b0, 4'h4, 32'h0);
      `CHK(rd[2:0], 3'h1)
      power_down_pin_i <= 1'b0;
      wake(PDW, PDW + 4);
      push(48'h123456789ABC);
      drain();
      // Stopped sample clock lets the buffer fill up
      sclk_run <= 1'b0;
      repeat (30) @(posedge ref_clk_i);
      repeat (16) push(48'({$urandom, $urandom}));
      @(posedge ref_clk_i);
      `CHK(sample_ready_o, 1'b0)
      sclk_run <= 1'b1;
      push(48'hFFF000FFF000);
      drain();
      setcfg(8'hFF);
      rst_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      cfg = 8'h00;
      bus(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h0)
      wrap_up();
   end
endmodule
